//--- rtl/pss_button.sv
// Power-button debouncer and press-length classifier
`timescale 1ns/1ps
module pss_button
   import pss_pkg::*;
#(
   parameter int DEB_CYC  = DEBOUNCE_CYC,
   parameter int LONG_CYC = LONG_PRESS_CYC
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset_n,
   // Raw button, low while pressed
   input  wire logic btn_n,
   // Classified presses
   output logic      short_press,
   output logic      long_press
);

   typedef struct packed {
      logic        stable;
      logic [31:0] deb_cnt;
      logic [31:0] hold_cnt;
      logic        long_done;
      logic        short_press;
      logic        long_press;
   } pss_btn_s;

   pss_btn_s r;
   pss_btn_s next_r;

   // ==========================================================
   // Debounce, then time the held level
   // ==========================================================
   always_comb begin
      next_r = r;
      next_r.short_press = 1'b0;
      next_r.long_press  = 1'b0;
      if (~btn_n != r.stable) begin
         if (r.deb_cnt >= 32'(DEB_CYC - 1)) begin
            next_r.stable  = ~btn_n;
            next_r.deb_cnt = 32'h0;
         end else begin
            next_r.deb_cnt = r.deb_cnt + 32'h1;
         end
      end else begin
         next_r.deb_cnt = 32'h0;
      end
      if (r.stable) begin
         if (!r.long_done) begin
            if (r.hold_cnt >= 32'(LONG_CYC - 1)) begin
               next_r.long_press = 1'b1;
               next_r.long_done  = 1'b1;
            end else begin
               next_r.hold_cnt = r.hold_cnt + 32'h1;
            end
         end
      end else begin
         // Released before the threshold: short press
         next_r.short_press = (r.hold_cnt != 32'h0) && !r.long_done;
         next_r.hold_cnt    = 32'h0;
         next_r.long_done   = 1'b0;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign short_press = r.short_press;
   assign long_press  = r.long_press;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   press_excl_a: assert property (!(short_press && long_press))
      else $error("short and long press together");
   long_time_a: assert property (
      long_press |-> $past(r.stable)
                     && r.hold_cnt == 32'(LONG_CYC - 1))
      else $error("long press before threshold");

endmodule

//--- rtl/pss_pkg.sv
// Constants and types shared by the power-state sequencer
package pss_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_MHZ        = 250;
   localparam int LONG_PRESS_MS  = 4000;
   localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CLK_MHZ * 1000;
   localparam int DEBOUNCE_MS    = 10;
   localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_MHZ * 1000;

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam int         ADDR_W    = 8;
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_CMD   = 8'h04;
   localparam logic [7:0] OFS_STATE = 8'h08;
   localparam logic [7:0] OFS_ISTAT = 8'h0C;
   localparam logic [7:0] OFS_IMASK = 8'h10;
   localparam logic [7:0] OFS_WCAUSE = 8'h14;

   // Control fields
   localparam int CTRL_SLEEP_S3 = 0;
   localparam int CTRL_S5_WAKE  = 1;
   localparam int CTRL_POL_LO   = 2;
   localparam logic [1:0] POL_RESTORE = 2'h0;
   localparam logic [1:0] POL_ON      = 2'h1;
   localparam logic [1:0] POL_OFF     = 2'h2;
   localparam logic [1:0] POL_RST     = 2'h0;

   // Command bits
   localparam int CMD_SLEEP    = 0;
   localparam int CMD_SUSPEND4 = 1;
   localparam int CMD_SOFT_OFF = 2;

   // Interrupt status bits
   localparam int INT_WAKE    = 0;
   localparam int INT_SHORT   = 1;
   localparam int INT_LONG    = 2;
   localparam int INT_AC_LOST = 3;
   localparam int INT_AC_BACK = 4;
   localparam int INT_W       = 5;
   localparam logic [4:0] IMASK_RST = 5'h00;

   // Wake sources and where each may act
   localparam int WK_LAN  = 0;
   localparam int WK_PME  = 1;
   localparam int WK_RING = 2;
   localparam int WK_PS2  = 3;
   localparam int WK_USB  = 4;
   localparam int WK_RTC  = 5;
   localparam int WK_N    = 6;
   localparam logic [5:0] WK_FROM_S13 = 6'h3F;
   localparam logic [5:0] WK_FROM_S4  = 6'h23;
   localparam logic [5:0] WK_FROM_S5  = 6'h20;
   localparam logic [5:0] WK_S5_GATED = 6'h03;

   // System power states
   typedef enum logic [2:0] {
      PSS_S0 = 3'b000,
      PSS_S1 = 3'b001,
      PSS_S3 = 3'b011,
      PSS_S4 = 3'b100,
      PSS_S5 = 3'b101,
      PSS_G3 = 3'b111
   } pss_state_e;

endpackage

//--- rtl/pss_sequencer.sv
// System power-state sequencer with register port and interrupt
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int DEB_CYC  = DEBOUNCE_CYC,
   parameter int LONG_CYC = LONG_PRESS_CYC
) (
   // Clock and power-good reset
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // Register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [31:0]            rdata,
   // Button, wake sources and mains sense
   input  wire logic              btn_n,
   input  wire logic [WK_N-1:0]   wake_src,
   input  wire logic              ac_ok,
   // Supply control and status
   output logic                   ps_on,
   output logic [2:0]             sys_state,
   output logic                   irq
);

   typedef struct packed {
      pss_state_e      state;
      logic            ps_on;
      logic            last_on;
      logic            sleep_s3;
      logic            s5_wake_en;
      logic [1:0]      policy;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_mask;
      logic [WK_N-1:0] wake_cause;
      logic [31:0]     rdata;
      logic            irq;
   } pss_seq_s;

   pss_seq_s         r;
   pss_seq_s         next_r;
   logic             short_press;
   logic             long_press;
   logic [WK_N-1:0]  wake_hit;
   logic [INT_W-1:0] ev;
   logic             wr_ctrl;
   logic             wr_cmd;
   logic             wr_istat;
   logic             wr_imask;
   pss_state_e       sleep_tgt;

   // ==========================================================
   // Sub-blocks
   // ==========================================================
   pss_button #(
      .DEB_CYC  (DEB_CYC),
      .LONG_CYC (LONG_CYC)
   ) u_button (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .btn_n       (btn_n),
      .short_press (short_press),
      .long_press  (long_press)
   );

   pss_wake u_wake (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .wake_src   (wake_src),
      .state      (r.state),
      .s5_wake_en (r.s5_wake_en),
      .wake_hit   (wake_hit)
   );

   // ==========================================================
   // Register decode
   // ==========================================================
   assign wr_ctrl  = wr_en && addr == OFS_CTRL;
   assign wr_cmd   = wr_en && addr == OFS_CMD;
   assign wr_istat = wr_en && addr == OFS_ISTAT;
   assign wr_imask = wr_en && addr == OFS_IMASK;
   assign sleep_tgt = r.sleep_s3 ? PSS_S3 : PSS_S1;

   // ==========================================================
   // Next state: power sequencing, registers, interrupt
   // ==========================================================
   always_comb begin
      next_r = r;
      ev     = '0;

      // Configuration writes
      if (wr_ctrl) begin
         next_r.sleep_s3   = wdata[CTRL_SLEEP_S3];
         next_r.s5_wake_en = wdata[CTRL_S5_WAKE];
         next_r.policy     = wdata[CTRL_POL_LO +: 2];
      end
      if (wr_imask) begin
         next_r.int_mask = wdata[INT_W-1:0];
      end

      // Power-state transitions, mains loss first
      if (!ac_ok) begin
         if (r.state != PSS_G3) begin
            ev[INT_AC_LOST] = 1'b1;
         end
         next_r.state = PSS_G3;
      end else if (r.state == PSS_G3) begin
         ev[INT_AC_BACK] = 1'b1;
         unique case (r.policy)
            POL_ON:  next_r.state = PSS_S0;
            POL_OFF: next_r.state = PSS_S5;
            default: next_r.state = r.last_on ? PSS_S0 : PSS_S5;
         endcase
      end else if (long_press && r.state != PSS_S5) begin
         next_r.state = PSS_S5;
      end else begin
         unique case (r.state)
            PSS_S0: begin
               // Only software commands, the button or mains loss leave S0
               if (short_press) begin
                  next_r.state = sleep_tgt;
               end else if (wr_cmd && wdata[CMD_SOFT_OFF]) begin
                  next_r.state = PSS_S5;
               end else if (wr_cmd && wdata[CMD_SLEEP]) begin
                  next_r.state = sleep_tgt;
               end else if (wr_cmd && wdata[CMD_SUSPEND4]) begin
                  next_r.state = PSS_S4;
               end
            end
            PSS_S1, PSS_S3, PSS_S4, PSS_S5: begin
               // Button or accepted source returns to work
               if (short_press || wake_hit != '0) begin
                  next_r.state = PSS_S0;
                  ev[INT_WAKE] = 1'b1;
                  next_r.wake_cause = wake_hit;
               end
            end
            default: next_r.state = PSS_G3;
         endcase
      end

      // Remember whether the system was on, for mains return
      if (r.state != PSS_G3) begin
         next_r.last_on = r.state != PSS_S5;
      end

      // Rails on only in working and S1; standby never dropped
      next_r.ps_on = next_r.state == PSS_S0
                     || next_r.state == PSS_S1;

      // Button events
      ev[INT_SHORT] = short_press;
      ev[INT_LONG]  = long_press;

      // Sticky status, write one to clear, set wins
      next_r.int_stat = (r.int_stat
                         & ~(wr_istat ? wdata[INT_W-1:0] : '0)) | ev;
      next_r.irq = (next_r.int_stat & next_r.int_mask) != '0;

      // Read data stand only in the cycle after the strobe
      next_r.rdata = 32'h0;
      if (rd_en) begin
         unique case (addr)
            OFS_CTRL: begin
               next_r.rdata[CTRL_SLEEP_S3]    = r.sleep_s3;
               next_r.rdata[CTRL_S5_WAKE]     = r.s5_wake_en;
               next_r.rdata[CTRL_POL_LO +: 2] = r.policy;
            end
            OFS_STATE:
               next_r.rdata[4:0] = {r.last_on, r.ps_on, r.state};
            OFS_ISTAT:  next_r.rdata[INT_W-1:0] = r.int_stat;
            OFS_IMASK:  next_r.rdata[INT_W-1:0] = r.int_mask;
            OFS_WCAUSE: next_r.rdata[WK_N-1:0]  = r.wake_cause;
            default:    next_r.rdata = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         r            <= '0;
         r.state      <= PSS_G3;
         r.s5_wake_en <= 1'b0;
         r.policy     <= POL_RST;
         r.int_mask   <= IMASK_RST;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign rdata     = r.rdata;
   assign ps_on     = r.ps_on;
   assign sys_state = r.state;
   assign irq       = r.irq;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   short_sleep_a: assert property (
      r.state == PSS_S0 && ac_ok && short_press
      |=> r.state == $past(sleep_tgt))
      else $error("short press in S0 did not sleep");

   short_wake_a: assert property (
      (r.state == PSS_S1 || r.state == PSS_S3 || r.state == PSS_S5)
      && ac_ok && short_press |=> r.state == PSS_S0 && ps_on)
      else $error("short press did not wake");

   long_off_a: assert property (
      long_press && ac_ok && r.state != PSS_G3
      |=> r.state == PSS_S5 && !ps_on)
      else $error("long press did not force soft-off");

   lan_s4_a: assert property (
      (r.state == PSS_S4 && $rose(wake_src[WK_LAN]))
      ##1 (ac_ok && !long_press) |=> r.state == PSS_S0)
      else $error("LAN did not wake from S4");

   ring_s3_a: assert property (
      (r.state == PSS_S3 && $rose(wake_src[WK_RING]))
      ##1 (ac_ok && !long_press) |=> r.state == PSS_S0)
      else $error("modem ring did not wake from S3");

   rtc_s5_a: assert property (
      (r.state == PSS_S5 && $rose(wake_src[WK_RTC]))
      ##1 ac_ok |=> r.state == PSS_S0)
      else $error("RTC alarm did not wake from S5");

   s5_reset_a: assert property (
      $rose(reset_n) |-> !r.s5_wake_en ##1 !r.s5_wake_en || $past(wr_ctrl))
      else $error("S5 wake enabled after reset");

   ac_restore_a: assert property (
      r.state == PSS_G3 && ac_ok && r.policy == POL_RESTORE
      |=> r.state == ($past(r.last_on) ? PSS_S0 : PSS_S5))
      else $error("prior state not restored");

   soft_off_a: assert property (
      r.state == PSS_S0 && ac_ok && !short_press && !long_press
      && wr_cmd && wdata[CMD_SOFT_OFF]
      |=> !ps_on && r.state == PSS_S5)
      else $error("soft-off left rails on");

   rails_match_a: assert property (
      ps_on == (r.state == PSS_S0 || r.state == PSS_S1))
      else $error("rail enable disagrees with state");

   idle_hold_a: assert property (
      r.state == PSS_S0 && ac_ok && !short_press && !long_press
      && !wr_cmd |=> r.state == PSS_S0)
      else $error("left S0 without a request");

   sticky_set_a: assert property (
      ev != '0 |=> (r.int_stat & $past(ev)) == $past(ev))
      else $error("event lost against clear");

   irq_level_a: assert property (
      irq == ((r.int_stat & r.int_mask) != '0))
      else $error("interrupt level wrong");

   // Mains loss drops every rail at once
   ac_loss_a: assert property (
      !ac_ok |=> r.state == PSS_G3 && !ps_on)
      else $error("mains loss left rails on");

   // Forced policies override the remembered state
   ac_pol_on_a: assert property (
      r.state == PSS_G3 && ac_ok && r.policy == POL_ON
      |=> r.state == PSS_S0 && ps_on)
      else $error("power-on policy ignored");

   ac_pol_off_a: assert property (
      r.state == PSS_G3 && ac_ok && r.policy == POL_OFF
      |=> r.state == PSS_S5 && !ps_on)
      else $error("stay-off policy ignored");

   // Commands act only in S0; sleep states wait for a wake
   cmd_gate_a: assert property (
      (r.state == PSS_S1 || r.state == PSS_S3 || r.state == PSS_S4
       || r.state == PSS_S5) && ac_ok && !short_press && !long_press
      && wake_hit == '0 |=> r.state == $past(r.state))
      else $error("left a sleep state without a wake");

   sleep_cmd_a: assert property (
      r.state == PSS_S0 && ac_ok && !short_press && !long_press
      && wr_cmd && wdata[CMD_SLEEP] && !wdata[CMD_SOFT_OFF]
      |=> r.state == $past(sleep_tgt))
      else $error("sleep command not executed");

   s4_cmd_a: assert property (
      r.state == PSS_S0 && ac_ok && !short_press && !long_press
      && wr_cmd && wdata[CMD_SOFT_OFF:CMD_SLEEP] == 3'h2
      |=> r.state == PSS_S4 && !ps_on)
      else $error("S4 command not executed");

   // Accepted wake returns to work and records its source
   wake_go_a: assert property (
      r.state != PSS_S0 && r.state != PSS_G3 && ac_ok && !long_press
      && wake_hit != '0 |=> r.state == PSS_S0 && r.int_stat[INT_WAKE])
      else $error("accepted wake did not reach S0");

   wake_cause_a: assert property (
      r.state != PSS_S0 && r.state != PSS_G3 && ac_ok && !long_press
      && wake_hit != '0 |=> r.wake_cause == $past(wake_hit))
      else $error("wake cause not captured");

   long_stat_a: assert property (
      long_press |=> r.int_stat[INT_LONG])
      else $error("long press not recorded");

   // Read data are zero unless a read was strobed
   rdata_idle_a: assert property (
      !rd_en |=> rdata == 32'h0)
      else $error("read data outside read cycle");

   cov_restore_c: cover property (
      r.state == PSS_G3 && ac_ok && r.policy == POL_RESTORE);
   cov_wake_s3_c: cover property (
      r.state == PSS_S3 ##1 r.state == PSS_S0);
   cov_long_c: cover property (long_press && r.state == PSS_S0);
   cov_ac_back_c: cover property (r.state == PSS_G3 && ac_ok);
   cov_soft_off_c: cover property (
      r.state == PSS_S0 && wr_cmd && wdata[CMD_SOFT_OFF]);

endmodule

//--- rtl/pss_wake.sv
// Wake-source qualifier: edge detect and per-state acceptance
`timescale 1ns/1ps
module pss_wake
   import pss_pkg::*;
(
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            reset_n,
   // Wake requests, high active
   input  wire logic [WK_N-1:0] wake_src,
   // Context
   input  wire pss_state_e      state,
   input  wire logic            s5_wake_en,
   // Accepted wake, one-cycle pulse per source
   output logic [WK_N-1:0]      wake_hit
);

   typedef struct packed {
      logic [WK_N-1:0] prev;
      logic [WK_N-1:0] hit;
   } pss_wake_s;

   pss_wake_s       r;
   pss_wake_s       next_r;
   logic [WK_N-1:0] allow;
   logic [WK_N-1:0] rise;

   // ==========================================================
   // Acceptance per source and state
   // ==========================================================
   for (genvar i = 0; i < WK_N; i++) begin : g_allow
      assign allow[i] =
         ((state == PSS_S1 || state == PSS_S3) && WK_FROM_S13[i])
         || (state == PSS_S4 && WK_FROM_S4[i])
         || (state == PSS_S5 && (WK_FROM_S5[i]
             || (WK_S5_GATED[i] && s5_wake_en)));
   end

   assign rise = wake_src & ~r.prev;

   // Register edges and accepted hits
   always_comb begin
      next_r      = r;
      next_r.prev = wake_src;
      next_r.hit  = rise & allow;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign wake_hit = r.hit;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   deep_block_a: assert property (
      (state == PSS_S4 || state == PSS_S5)
      && (rise & WK_FROM_S4) == '0 |=> wake_hit == '0)
      else $error("modem, PS/2 or USB woke from S4/S5");
   rtc_wake_a: assert property (
      state != PSS_S0 && state != PSS_G3 && rise[WK_RTC]
      |=> wake_hit[WK_RTC])
      else $error("RTC alarm not accepted");
   s5_gate_a: assert property (
      state == PSS_S5 && !s5_wake_en
      |=> (wake_hit & WK_S5_GATED) == '0)
      else $error("LAN/PME woke S5 while disabled");

endmodule

//--- test/pss_far_side.sv
// Far-side model: power button, wake sources and mains supply
`timescale 1ns/1ps
module pss_far_side
   import pss_pkg::*;
(
   // Clock
   input  wire logic       mclk,
   // Towards the sequencer
   output logic            btn_n,
   output logic [WK_N-1:0] wake_src,
   output logic            ac_ok
);
   // Idle: button up on its pull-up, no wake request, mains present
   initial begin
      btn_n    = 1'b1;
      wake_src = '0;
      ac_ok    = 1'b1;
   end

   // ==========================================================
   // Stimulus tasks, all changes right after a rising edge
   // ==========================================================
   // Hold the button down for a number of cycles
   task automatic press(input int cyc);
      @(posedge mclk);
      btn_n <= 1'b0;
      repeat (cyc) @(posedge mclk);
      btn_n <= 1'b1;
   endtask

   // One rising edge on one wake source
   task automatic wake(input int src);
      @(posedge mclk);
      wake_src <= 6'h01 << src;
      @(posedge mclk);
      wake_src <= '0;
   endtask

   // Mains present or lost
   task automatic mains(input logic on);
      @(posedge mclk);
      ac_ok <= on;
   endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the power-state sequencer
`timescale 1ns/1ps
module tb_top
   import pss_pkg::*;
;
   localparam int DEB = 4;
   localparam int LNG = 50;
   logic              mclk = 1'b0;
   logic              reset_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [31:0]       wdata = '0;
   logic              wr_en = 1'b0;
   logic              rd_en = 1'b0;
   logic [31:0]       rdata;
   logic [31:0]       rd;
   logic [31:0]       ctrl = '0;
   logic              btn_n;
   logic              ac_ok;
   logic              ps_on;
   logic              irq;
   logic [WK_N-1:0]   wake_src;
   logic [2:0]        sys_state;
   int                n_errors = 0;
   int                tests_run = 0;

   // Clock, 4 ns period
   always #2 mclk = ~mclk;

   pss_sequencer #(.DEB_CYC(DEB), .LONG_CYC(LNG)) i_pss_sequencer (
      .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .btn_n(btn_n),
      .wake_src(wake_src), .ac_ok(ac_ok), .ps_on(ps_on),
      .sys_state(sys_state), .irq(irq));

   pss_far_side i_pss_far_side (
      .mclk(mclk), .btn_n(btn_n), .wake_src(wake_src), .ac_ok(ac_ok));

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic chk(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      @(negedge mclk);
      rd = rdata;
   endtask

   task automatic st(input logic [2:0] s, input logic p);
      chk("sys_state", 32'(sys_state), 32'(s));
      chk("ps_on", 32'(ps_on), 32'(p));
   endtask

   task automatic short_press;
      i_pss_far_side.press(DEB + 2);
      cyc(DEB + 4);
   endtask

   task automatic to_s0;
      if (sys_state !== PSS_S0) short_press();
   endtask

   // Software command from S0 into a sleep or off state
   task automatic go(input logic [2:0] s);
      wr(OFS_CTRL, ctrl | 32'(s == PSS_S3));
      wr(OFS_CMD, s == PSS_S4 ? 32'h02 : s == PSS_S5 ? 32'h04 : 32'h01);
      cyc(3);
      st(s, s == PSS_S1);
   endtask

   // Which wake source may act from which state
   function automatic logic ok(int src, logic [2:0] s, logic en);
      if (src == WK_RTC) return 1'b1;
      if (s == PSS_S1 || s == PSS_S3) return 1'b1;
      if (src > WK_PME) return 1'b0;
      return s == PSS_S4 || en;
   endfunction

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset;
      st(PSS_S5, 1'b0);
      rd_reg(OFS_CTRL);
      chk("ctrl reset", rd, 32'h00000000);
      rd_reg(8'h1C);
      chk("unmapped read", rd, 32'h00000000);
   endtask

   task automatic t_button;
      short_press();
      st(PSS_S0, 1'b1);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CTRL, 32'(i == 0));
         short_press();
         st(i == 0 ? PSS_S3 : PSS_S1, i == 1);
         short_press();
         st(PSS_S0, 1'b1);
      end
      i_pss_far_side.press(DEB - 2);
      cyc(DEB + 4);
      st(PSS_S0, 1'b1);
   endtask

   task automatic t_long;
      wr(OFS_IMASK, 32'h04);
      for (int i = 0; i < 2; i++) begin
         to_s0();
         if (i == 1) go(PSS_S3);
         fork
            i_pss_far_side.press(DEB + LNG + 20);
            begin
               cyc(DEB + LNG + 6);
               st(PSS_S5, 1'b0);
               chk("irq long", 32'(irq), 32'h1);
            end
         join
         cyc(DEB + 4);
         st(PSS_S5, 1'b0);
         rd_reg(OFS_ISTAT);
         chk("long status", 32'(rd[INT_LONG]), 32'h1);
         wr(OFS_ISTAT, 32'h04);
         cyc(2);
         chk("irq cleared", 32'(irq), 32'h0);
      end
      wr(OFS_IMASK, 32'h00);
      i_pss_far_side.press(DEB + LNG + 8);
      cyc(DEB + 4);
      chk("irq masked", 32'(irq), 32'h0);
   endtask

   task automatic t_wake;
      logic [2:0] sl[4] = '{PSS_S1, PSS_S3, PSS_S4, PSS_S5};
      logic [2:0] e;
      for (int en = 0; en < 2; en++) begin
         ctrl = 32'(en) << CTRL_S5_WAKE;
         for (int k = 0; k < 4; k++) begin
            for (int src = 0; src < WK_N; src++) begin
               to_s0();
               go(sl[k]);
               i_pss_far_side.wake(src);
               cyc(3);
               e = ok(src, sl[k], en[0]) ? PSS_S0 : sl[k];
               st(e, e != PSS_S4 && e != PSS_S5 && e != PSS_S3);
               rd_reg(OFS_WCAUSE);
               if (e == PSS_S0) chk("wake cause", rd, 32'h01 << src);
            end
         end
      end
      to_s0();
      go(PSS_S4);
      short_press();
      st(PSS_S0, 1'b1);
      ctrl = '0;
   endtask

   task automatic t_ac;
      logic [1:0] pol[4] = '{POL_RESTORE, POL_RESTORE, POL_ON, POL_OFF};
      logic [2:0] src_s[4] = '{PSS_S0, PSS_S5, PSS_S5, PSS_S0};
      logic [2:0] dst_s[4] = '{PSS_S0, PSS_S5, PSS_S0, PSS_S5};
      for (int i = 0; i < 4; i++) begin
         to_s0();
         ctrl = 32'(pol[i]) << CTRL_POL_LO;
         wr(OFS_CTRL, ctrl);
         if (src_s[i] == PSS_S5) go(PSS_S5);
         i_pss_far_side.mains(1'b0);
         cyc(2);
         st(PSS_G3, 1'b0);
         i_pss_far_side.mains(1'b1);
         cyc(2);
         st(dst_s[i], dst_s[i] == PSS_S0);
      end
      ctrl = '0;
   endtask

   // ==========================================================
   // Verdict, main sequence and watchdog
   // ==========================================================
   task automatic end_of_test;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      cyc(2);
      t_reset();
      t_button();
      t_long();
      t_wake();
      t_ac();
      end_of_test();
   end

   // Cut a hang short well past the expected run length
   initial begin
      #100000;
      n_errors++;
      end_of_test();
   end
endmodule
